// [hw/mpt_core.sv]
`timescale 1ns/1ps
module mpt_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Register bus
	input wire logic bus_cs_i,
	input wire logic bus_we_i,
	input wire logic [1:0] bus_be_i,
	input wire logic [mpt_pkg::ADDR_W-1:0] bus_addr_i,
	input wire mpt_pkg::mpt_word_t bus_wdata_i,
	output mpt_pkg::mpt_word_t bus_rdata_o,
	output logic bus_ack_o,
	// Timer pins
	input wire logic [mpt_pkg::NPIN-1:0] timer_io_pin_i,
	output logic [mpt_pkg::NPIN-1:0] timer_io_pin_o,
	output logic [mpt_pkg::NPIN-1:0] timer_io_pin_oe_o,
	input wire logic [mpt_pkg::NEXT-1:0] external_count_clock_pin_i,
	// Interrupt requests
	output logic [mpt_pkg::NCH-1:0] timer_irq_o
);
	import mpt_pkg::*;

	// Register state
	mpt_word_t cnt [NCH];
	mpt_word_t next_cnt [NCH];
	mpt_word_t gr [NCH][NGR];
	mpt_word_t next_gr [NCH][NGR];
	mpt_word_t io [NCH];
	mpt_word_t next_io [NCH];
	logic [7:0] ctrl [NCH];
	logic [7:0] next_ctrl [NCH];
	logic [7:0] mode [NCH];
	logic [7:0] next_mode [NCH];
	logic [7:0] ien [NCH];
	logic [7:0] next_ien [NCH];
	logic [FLAG_W-1:0] sts [NCH];
	logic [FLAG_W-1:0] next_sts [NCH];
	logic [FLAG_W-1:0] seen [NCH];
	logic [FLAG_W-1:0] next_seen [NCH];
	logic [2:0] start, next_start;
	logic [2:0] sync_sel, next_sync_sel;
	logic [PRE_W-1:0] pre, next_pre;
	logic [NPIN-1:0] pin, next_pin;
	logic [NPIN-1:0] pin_oe, next_pin_oe;
	mpt_word_t rdata, next_rdata;
	logic ack, next_ack;
	logic [NCH-1:0] irq, next_irq;

	// Decoded events
	logic wr, rd, full, sync_clr, sync_wr;
	logic [1:0] ch;
	logic [2:0] wi;
	logic [NCH-1:0] tick, down, phase, clr_own, clr_any, cnt_wr, io_wr;
	logic [NGR-1:0] match [NCH];
	logic [NGR-1:0] capt [NCH];

	mpt_edge_if eif();

	mpt_edge u_edge (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(timer_io_pin_i),
		.ext_i(external_count_clock_pin_i),
		.eif(eif.det)
	);

	function automatic logic [2:0] pin_idx(int c, int g);
		return 3'(PIN_BASE[c] + 3'(g));
	endfunction

	// Bus decode and per-channel count, match and capture events
	always_comb begin
		wr = bus_cs_i & bus_we_i;
		rd = bus_cs_i & ~bus_we_i;
		ch = bus_addr_i[CH_LSB+:2];
		wi = bus_addr_i[WI_LSB+:3];
		full = (bus_be_i == BE_WORD);
		sync_clr = 1'b0;
		sync_wr = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			cnt_wr[c] = wr && ch == 2'(c) && wi == WI_CNT && full; // [R7]
			io_wr[c] = wr && ch == 2'(c) && wi == WI_IO;
			phase[c] = PHASE_CH[c] && mode[c][3:0] == MODE_PHASE;
			if (phase[c]) begin
				tick[c] = start[c] & (eif.qd_up[c] | eif.qd_dn[c]); // [R20]
				down[c] = eif.qd_dn[c];
			end else if (ctrl[c][CKS_EXT_BIT]) begin
				tick[c] = start[c] & eif.ext_rise[ctrl[c][1:0]]; // [R9]
				down[c] = 1'b0;
			end else begin
				tick[c] = start[c] & pre_tick(pre, ctrl[c][1:0]); // [R9] [R21]
				down[c] = 1'b0;
			end
			clr_own[c] = 1'b0;
			for (int g = 0; g < NGR; g++) begin
				// Buffer registers stand aside from matching and capturing
				if (GR_MASK[c][g] && !(BUF_CH[c] && g >= 2 && mode[c][BUF_A_BIT+g-2])) begin
					match[c][g] = !is_cap(io[c], g) && tick[c] &&
						cnt[c] == gr[c][g]; // [R15]
					capt[c][g] = is_cap(io[c], g) && cap_hit(out_code(io[c], g),
						eif.pin_rise[pin_idx(c, g)],
						eif.pin_fall[pin_idx(c, g)]); // [R14] [R15]
				end else begin
					match[c][g] = 1'b0;
					capt[c][g] = 1'b0;
				end
				if ((match[c][g] || capt[c][g]) && ctrl[c][CCLR_LSB+:3] == CCLR_GR[g]) begin
					clr_own[c] = 1'b1; // [R11] [R16]
				end
			end
			sync_clr = sync_clr | (sync_sel[c] & clr_own[c]); // [R1] [R6]
			sync_wr = sync_wr | (sync_sel[c] & cnt_wr[c]); // [R5]
		end
		for (int c = 0; c < NCH; c++) begin
			// Sync clear only where the clear field asks for it
			clr_any[c] = clr_own[c] || (sync_sel[c] &&
				ctrl[c][CCLR_LSB+:3] == CCLR_SYNC && sync_clr); // [R4] [R6]
		end
	end

	// Next state of registers, counters, pins and bus answer
	always_comb begin
		next_start = start;
		next_sync_sel = sync_sel;
		next_pre = PRE_W'(pre + 1'b1);
		next_pin = pin;
		next_pin_oe = pin_oe;
		next_ack = bus_cs_i;
		next_rdata = '0;
		for (int c = 0; c < NCH; c++) begin
			next_cnt[c] = cnt[c];
			next_io[c] = io[c];
			next_ctrl[c] = ctrl[c];
			next_mode[c] = mode[c];
			next_ien[c] = ien[c];
			next_sts[c] = sts[c];
			next_seen[c] = seen[c];
			for (int g = 0; g < NGR; g++) begin
				next_gr[c][g] = gr[c][g];
			end
		end

		// Reads; reserved bits and unmapped words read zero
		if (rd) begin
			if (ch == GLB_CH) begin
				if (wi == WI_START_SYNC) begin
					next_rdata = {5'h00, start, 5'h00, sync_sel}; // [R2] [R23]
				end
			end else begin
				for (int c = 0; c < NCH; c++) begin
					if (ch == 2'(c)) begin
						case (wi)
							WI_CTRL: next_rdata = {ctrl[c], mode[c]}; // [R23]
							WI_IO: next_rdata = io[c];
							WI_IRQ: begin
								next_rdata = {ien[c], 3'h0, sts[c]};
								// Arm flag clearing only for bits seen set
								if (bus_be_i[BE_LO]) next_seen[c] = seen[c] | sts[c];
							end
							WI_CNT: next_rdata = cnt[c];
							default: begin
								if (GR_MASK[c][wi[1:0]]) next_rdata = gr[c][wi[1:0]];
							end
						endcase
					end
				end
			end
		end

		// Writes to byte-wide registers merge per lane
		if (wr && ch == GLB_CH && wi == WI_START_SYNC) begin
			if (bus_be_i[BE_HI]) next_start = bus_wdata_i[BYTE_HI_LSB+:3]; // [R8] [R9]
			if (bus_be_i[BE_LO]) next_sync_sel = bus_wdata_i[2:0]; // [R1] [R8]
		end
		for (int c = 0; c < NCH; c++) begin
			if (wr && ch == 2'(c)) begin
				case (wi)
					WI_CTRL: {next_ctrl[c], next_mode[c]} =
						bmerge({ctrl[c], mode[c]}, bus_wdata_i, bus_be_i); // [R8] [R23]
					WI_IO: next_io[c] = bmerge(io[c], bus_wdata_i, bus_be_i); // [R8]
					WI_IRQ: begin
						if (bus_be_i[BE_HI]) next_ien[c] = bus_wdata_i[BYTE_HI_LSB+:8];
						if (bus_be_i[BE_LO]) begin
							next_sts[c] = sts[c] & ~(seen[c] & ~bus_wdata_i[FLAG_W-1:0]);
							next_seen[c] = seen[c] & bus_wdata_i[FLAG_W-1:0];
						end
					end
					WI_CNT: ;
					default: begin
						// Word-only register: partial writes are dropped
						if (full && GR_MASK[c][wi[1:0]]) begin
							next_gr[c][wi[1:0]] = bus_wdata_i; // [R7]
						end
					end
				endcase
			end
		end

		for (int c = 0; c < NCH; c++) begin
			// Counter: preset beats clear, clear beats counting
			if (cnt_wr[c] || (sync_wr && sync_sel[c])) begin
				next_cnt[c] = bus_wdata_i; // [R5]
			end else if (clr_any[c]) begin
				next_cnt[c] = CNT_RST; // [R6] [R11]
			end else if (tick[c]) begin
				if (down[c]) begin
					next_cnt[c] = mpt_word_t'(cnt[c] - 1'b1); // [R20]
				end else begin
					next_cnt[c] = mpt_word_t'(cnt[c] + 1'b1); // [R10]
					if (cnt[c] == CNT_MAX) next_sts[c][OVF_BIT] = 1'b1; // [R10]
				end
			end

			for (int g = 0; g < NGR; g++) begin
				// Flags set after software clear, so a same-cycle event wins
				if (match[c][g] || capt[c][g]) next_sts[c][g] = 1'b1; // [R11] [R14]
				if (capt[c][g]) next_gr[c][g] = cnt[c]; // [R14]
			end

			// Buffer pairs A-C and B-D
			if (BUF_CH[c]) begin
				for (int g = 0; g < 2; g++) begin
					if (mode[c][BUF_A_BIT+g]) begin
						if (match[c][g]) next_gr[c][g] = gr[c][g+2]; // [R17]
						if (capt[c][g]) next_gr[c][g+2] = gr[c][g]; // [R18]
					end
				end
			end

			for (int g = 0; g < NGR; g++) begin
				if (GR_MASK[c][g]) begin
					if (io_wr[c] && !start[c]) begin
						// Stopped counter: a new setting shows its initial level
						next_pin[pin_idx(c, g)] = init_bit(next_io[c], g);
					end else if (mode[c][3:0] == MODE_PWM1) begin
						// Paired matches on one cycle cancel, leaving the pin as is
						if (g % 2 == 0 && (match[c][g] ^ match[c][g|1])) begin
							next_pin[pin_idx(c, g)] = apply_out(pin[pin_idx(c, g)],
								match[c][g] ? out_code(io[c], g) :
								out_code(io[c], g|1)); // [R19]
						end
					end else if (mode[c][3:0] == MODE_PWM2 && clr_any[c]) begin
						next_pin[pin_idx(c, g)] = init_bit(io[c], g); // [R19]
					end else if (match[c][g]) begin
						// Same level commanded leaves the flip-flop unchanged
						next_pin[pin_idx(c, g)] = apply_out(pin[pin_idx(c, g)],
							out_code(io[c], g)); // [R12] [R13]
					end
					next_pin_oe[pin_idx(c, g)] = !is_cap(next_io[c], g) &&
						out_code(next_io[c], g) != OUT_OFF &&
						!(next_mode[c][3:0] == MODE_PWM1 && g % 2 == 1);
				end
			end
			next_irq[c] = |(next_sts[c] & next_ien[c][FLAG_W-1:0]); // [R10] [R11]
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			start <= CH3_RST; // [R21]
			sync_sel <= CH3_RST; // [R1]
			pre <= '0;
			pin <= '0;
			pin_oe <= '0;
			rdata <= CNT_RST;
			ack <= 1'b0;
			irq <= '0;
			for (int c = 0; c < NCH; c++) begin
				cnt[c] <= CNT_RST; // [R22]
				io[c] <= CNT_RST;
				ctrl[c] <= BYTE_RST;
				mode[c] <= BYTE_RST;
				ien[c] <= BYTE_RST;
				sts[c] <= '0;
				seen[c] <= '0;
				for (int g = 0; g < NGR; g++) begin
					gr[c][g] <= GR_RST; // [R22]
				end
			end
		end else begin
			start <= next_start;
			sync_sel <= next_sync_sel;
			pre <= next_pre;
			pin <= next_pin;
			pin_oe <= next_pin_oe;
			rdata <= next_rdata;
			ack <= next_ack;
			irq <= next_irq;
			for (int c = 0; c < NCH; c++) begin
				cnt[c] <= next_cnt[c];
				io[c] <= next_io[c];
				ctrl[c] <= next_ctrl[c];
				mode[c] <= next_mode[c];
				ien[c] <= next_ien[c];
				sts[c] <= next_sts[c];
				seen[c] <= next_seen[c];
				for (int g = 0; g < NGR; g++) begin
					gr[c][g] <= next_gr[c][g];
				end
			end
		end
	end

	// Outputs straight from flip-flops
	assign bus_rdata_o = rdata;
	assign bus_ack_o = ack;
	assign timer_io_pin_o = pin;
	assign timer_io_pin_oe_o = pin_oe;
	assign timer_irq_o = irq;
endmodule

// [hw/mpt_edge.sv]
`timescale 1ns/1ps
module mpt_edge (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Pin samples
	input wire logic [mpt_pkg::NPIN-1:0] pin_i,
	input wire logic [mpt_pkg::NEXT-1:0] ext_i,
	// Edge events
	mpt_edge_if.det eif
);
	import mpt_pkg::*;

	logic [NPIN-1:0] pin_q, next_pin_q;
	logic [NEXT-1:0] ext_q, next_ext_q;

	// Previous samples; inputs already synchronous, so no extra stage
	always_comb begin
		next_pin_q = pin_i;
		next_ext_q = ext_i;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_q <= '0;
			ext_q <= '0;
		end else begin
			pin_q <= next_pin_q;
			ext_q <= next_ext_q;
		end
	end

	// Edge pulses and quadrature steps, one cycle each
	always_comb begin
		eif.pin_rise = pin_i & ~pin_q;
		eif.pin_fall = ~pin_i & pin_q;
		eif.ext_rise = ext_i & ~ext_q;
		eif.qd_up = '0;
		eif.qd_dn = '0;
		for (int c = 1; c < NCH; c++) begin
			{eif.qd_up[c], eif.qd_dn[c]} = quad(ext_i[2*c-2], ext_i[2*c-1],
				ext_q[2*c-2], ext_q[2*c-1]); // [R20]
		end
	end
endmodule

// [hw/mpt_edge_if.sv]
`timescale 1ns/1ps
interface mpt_edge_if;
	import mpt_pkg::*;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;
	logic [NEXT-1:0] ext_rise;
	logic [NCH-1:0] qd_up;
	logic [NCH-1:0] qd_dn;
	modport det (output pin_rise, pin_fall, ext_rise, qd_up, qd_dn);
	modport core (input pin_rise, pin_fall, ext_rise, qd_up, qd_dn);
endinterface

// [hw/mpt_pkg.sv]
// Function
// (R1) Three sync select bits pick independent or synchronous counting; reset to zero.
// (R2) Upper five sync select bits read zero; software writes them zero.
// (R3) Software selects at least two channels for synchronous operation.
// (R4) Synchronous clearing also needs the channel clear select set to sync.
// (R5) Counter write on a synced channel loads all synced counters together.
// (R6) Own clear of a synced channel clears synced channels selecting sync clear.
// (R7) Counters and general registers are accessed as whole 16-bit words only.
// (R8) Other registers are 8-bit and accept byte or 16-bit access.
// (R9) Counter start bit at one lets the channel count on its clock.
// (R10) Free-running wrap sets overflow flag, may request interrupt, continues from zero.
// (R11) Compare match clearing sets match flag, zeroes counter, may request interrupt.
// (R12) Compare match drives pin low, high or toggled per output setting.
// (R13) Commanded level equal to current pin level leaves the pin steady.
// (R14) Capture copies counter into general register on rising, falling or both edges.
// (R15) Each general register is set as output compare or input capture.
// (R16) Input capture may be chosen as the counter clearing source.
// (R17) Buffered compare copies buffer register into general register at match.
// (R18) Buffered capture moves old general value into buffer, counter into general.
// (R19) Pulse-width modes give duty from zero to full via general registers.
// (R20) Phase counting on channels 1 and 2 counts up or down from two inputs.
// (R21) Counter start bits reset to zero, holding counters stopped.
// (R22) Reset sets general registers to all ones and counters to zero.
// (R23) In 16-bit access the even-address byte is upper, odd-address lower.
package mpt_pkg;
	localparam int NCH = 3;
	localparam int NGR = 4;
	localparam int NPIN = 8;
	localparam int NEXT = 4;
	localparam int ADDR_W = 6;
	localparam int PRE_W = 6;
	localparam int IO_NIB_W = 4;
	localparam int BYTE_HI_LSB = 8;

	typedef logic [15:0] mpt_word_t;

	// Reset values and counter maximum
	localparam mpt_word_t CNT_RST = 16'h0000;
	localparam mpt_word_t CNT_MAX = 16'hffff;
	localparam mpt_word_t GR_RST = 16'hffff;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [2:0] CH3_RST = 3'h0;

	// Address decode: channel in [5:4], word index in [3:1]
	localparam int CH_LSB = 4;
	localparam int WI_LSB = 1;
	localparam logic [1:0] GLB_CH = 2'h3;
	localparam logic [2:0] WI_CTRL = 3'h0;
	localparam logic [2:0] WI_IO = 3'h1;
	localparam logic [2:0] WI_IRQ = 3'h2;
	localparam logic [2:0] WI_CNT = 3'h3;
	localparam int WI_GR_BIT = 2;
	localparam logic [2:0] WI_START_SYNC = 3'h0;
	localparam int BE_HI = 1;
	localparam int BE_LO = 0;
	localparam logic [1:0] BE_WORD = 2'h3;

	// Control byte fields
	localparam int CKS_EXT_BIT = 2;
	localparam int CCLR_LSB = 5;
	localparam logic [2:0] CCLR_GRA = 3'h1;
	localparam logic [2:0] CCLR_GRB = 3'h2;
	localparam logic [2:0] CCLR_SYNC = 3'h3;
	localparam logic [2:0] CCLR_GRC = 3'h5;
	localparam logic [2:0] CCLR_GRD = 3'h6;
	localparam logic [2:0] CCLR_GR [NGR] = '{CCLR_GRA, CCLR_GRB, CCLR_GRC, CCLR_GRD};

	// Mode byte fields
	localparam logic [3:0] MODE_PWM1 = 4'h2;
	localparam logic [3:0] MODE_PWM2 = 4'h3;
	localparam logic [3:0] MODE_PHASE = 4'h4;
	localparam int BUF_A_BIT = 4;

	// Interrupt enable and status fields
	localparam int OVF_BIT = 4;
	localparam int FLAG_W = 5;

	// I/O control nibble
	localparam int IO_CAP_BIT = 3;
	localparam int IO_INIT_BIT = 2;
	localparam logic [1:0] OUT_OFF = 2'h0;
	localparam logic [1:0] OUT_LOW = 2'h1;
	localparam logic [1:0] OUT_HIGH = 2'h2;
	localparam logic [1:0] OUT_TOG = 2'h3;
	localparam logic [1:0] CAP_RISE = 2'h0;
	localparam logic [1:0] CAP_FALL = 2'h1;

	// Channel shape
	localparam logic [NGR-1:0] GR_MASK [NCH] = '{4'hf, 4'h3, 4'h3};
	localparam logic [2:0] PIN_BASE [NCH] = '{3'h0, 3'h4, 3'h6};
	localparam logic [NCH-1:0] PHASE_CH = 3'h6;
	localparam logic [NCH-1:0] BUF_CH = 3'h1;

	function automatic mpt_word_t bmerge(mpt_word_t old, mpt_word_t wd, logic [1:0] be);
		mpt_word_t r;
		r = old;
		if (be[BE_HI]) r[BYTE_HI_LSB+:8] = wd[BYTE_HI_LSB+:8];
		if (be[BE_LO]) r[0+:8] = wd[0+:8];
		return r;
	endfunction

	function automatic logic apply_out(logic lvl, logic [1:0] code);
		case (code)
			OUT_LOW: return 1'b0;
			OUT_HIGH: return 1'b1;
			OUT_TOG: return ~lvl;
			default: return lvl;
		endcase
	endfunction

	function automatic logic pre_tick(logic [PRE_W-1:0] pre, logic [1:0] sel);
		case (sel)
			2'h0: return 1'b1;
			2'h1: return pre[1:0] == 2'h0;
			2'h2: return pre[3:0] == 4'h0;
			default: return pre == '0;
		endcase
	endfunction

	function automatic logic cap_hit(logic [1:0] sel, logic r, logic f);
		case (sel)
			CAP_RISE: return r;
			CAP_FALL: return f;
			default: return r | f;
		endcase
	endfunction

	function automatic logic [1:0] out_code(mpt_word_t io, int g);
		return io[g*IO_NIB_W+:2];
	endfunction

	function automatic logic is_cap(mpt_word_t io, int g);
		return io[g*IO_NIB_W+IO_CAP_BIT];
	endfunction

	function automatic logic init_bit(mpt_word_t io, int g);
		return io[g*IO_NIB_W+IO_INIT_BIT];
	endfunction

	// Quadrature step: {up, down}; A leading B counts up
	function automatic logic [1:0] quad(logic a, logic b, logic aq, logic bq);
		logic ar, af, br, bf;
		ar = a & ~aq;
		af = ~a & aq;
		br = b & ~bq;
		bf = ~b & bq;
		return {(ar & ~b) | (af & b) | (br & a) | (bf & ~a),
			(ar & b) | (af & ~b) | (br & ~a) | (bf & a)};
	endfunction
endpackage

// [tb/mpt_core_monitor.sv]
`timescale 1ns/1ps
module mpt_core_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Register bus
	input wire logic bus_cs_i,
	input wire logic bus_we_i,
	input wire logic [1:0] bus_be_i,
	input wire logic [mpt_pkg::ADDR_W-1:0] bus_addr_i,
	input wire mpt_pkg::mpt_word_t bus_wdata_i,
	input wire mpt_pkg::mpt_word_t bus_rdata_o,
	input wire logic bus_ack_o,
	// Pins and requests
	input wire logic [mpt_pkg::NPIN-1:0] timer_io_pin_oe_o,
	input wire logic [mpt_pkg::NCH-1:0] timer_irq_o
);
	import mpt_pkg::*;
	logic glb_rd;
	logic glb_wr;
	logic wr_any;
	// Start and sync bytes share the first word of the last slot
	assign glb_rd = bus_cs_i && !bus_we_i && bus_addr_i[5:1] == 5'h18;
	assign glb_wr = bus_cs_i && bus_we_i && bus_be_i[0] && bus_addr_i[5:1] == 5'h18;
	assign wr_any = bus_cs_i && bus_we_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_ack_next: assert property (bus_cs_i |=> bus_ack_o)
		else $error("ack missing after access");
	a_ack_cause: assert property (bus_ack_o |-> $past(bus_cs_i))
		else $error("ack without access");
	a_rdata_quiet: assert property (!(bus_cs_i && !bus_we_i) |=> bus_rdata_o == 16'h0000)
		else $error("read data outside read answer");
	a_sync_reserved: assert property (glb_rd |=> bus_rdata_o[7:3] == 5'h00)
		else $error("sync reserved bits not zero");
	a_start_reserved: assert property (glb_rd |=> bus_rdata_o[15:11] == 5'h00)
		else $error("start reserved bits not zero");
	a_sync_readback: assert property (glb_rd && !$past(bus_cs_i) && $past(glb_wr, 2)
		|=> bus_rdata_o[2:0] == $past(bus_wdata_i[2:0], 3))
		else $error("sync select readback wrong");
	// Requests only drop, and pin enables only rise, through a register write
	a_irq_fall: assert property (|($past(timer_irq_o) & ~timer_irq_o)
		|-> $past(wr_any) || $past(wr_any, 2))
		else $error("request dropped without write");
	a_oe_rise: assert property (|(timer_io_pin_oe_o & ~$past(timer_io_pin_oe_o))
		|-> $past(wr_any) || $past(wr_any, 2))
		else $error("pin enable rose without write");
endmodule
bind mpt_core mpt_core_monitor i_mon (.clk_i, .arst_n_i, .bus_cs_i, .bus_we_i, .bus_be_i,
	.bus_addr_i, .bus_wdata_i, .bus_rdata_o, .bus_ack_o, .timer_io_pin_oe_o, .timer_irq_o);

// [tb/mpt_core_tb.sv]
`timescale 1ns/1ps
module mpt_core_tb;
	import mpt_pkg::*;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic bus_cs, bus_we, bus_ack;
	logic [1:0] bus_be;
	logic [ADDR_W-1:0] bus_addr;
	mpt_word_t bus_wdata, bus_rdata;
	logic [NPIN-1:0] pin_drv = '0;
	logic [NEXT-1:0] ext_drv = '0;
	logic [NPIN-1:0] pin_o, pin_oe, pin_w;
	logic [NCH-1:0] irq;
	int failures = 0;
	int checks = 0;

	// 250 MHz clock
	always #2 clk_i = ~clk_i;
	// Pin level: core wins where it drives, bench elsewhere
	assign pin_w = (pin_o & pin_oe) | (pin_drv & ~pin_oe);

	mpt_cpu_model i_cpu (.clk_i(clk_i), .bus_cs_o(bus_cs), .bus_we_o(bus_we),
		.bus_be_o(bus_be), .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata),
		.bus_rdata_i(bus_rdata));
	mpt_core i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_cs_i(bus_cs),
		.bus_we_i(bus_we), .bus_be_i(bus_be), .bus_addr_i(bus_addr),
		.bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata), .bus_ack_o(bus_ack),
		.timer_io_pin_i(pin_w), .timer_io_pin_o(pin_o), .timer_io_pin_oe_o(pin_oe),
		.external_count_clock_pin_i(ext_drv), .timer_irq_o(irq));

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdc(input string nm, input logic [5:0] a, input logic [15:0] exp);
		mpt_word_t d;
		i_cpu.rd(a, d);
		chk(nm, d, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic t_reset();
		rdc("start_sync", 6'h30, 16'h0000);
		rdc("cnt0", 6'h06, 16'h0000);
		rdc("gra0", 6'h08, 16'hffff);
		rdc("grb2", 6'h2a, 16'hffff);
	endtask
	// Byte lanes, reserved bits and a refused byte write to a counter
	task automatic t_access();
		i_cpu.wr(6'h30, 16'h0007, 2'h1);
		rdc("sync_byte", 6'h30, 16'h0007);
		i_cpu.wr(6'h30, 16'h0000, 2'h3);
		i_cpu.wr(6'h20, 16'h0104, 2'h3);
		rdc("ctrl_mode2", 6'h20, 16'h0104);
		i_cpu.wr(6'h20, 16'h0000, 2'h1);
		rdc("ctrl_only2", 6'h20, 16'h0100);
		i_cpu.wr(6'h20, 16'h0000, 2'h2);
		i_cpu.wr(6'h06, 16'h1234, 2'h1);
		rdc("cnt0_byte", 6'h06, 16'h0000);
	endtask
	task automatic t_preset();
		i_cpu.wr(6'h30, 16'h0003, 2'h1);
		i_cpu.wr(6'h06, 16'h1234, 2'h3);
		rdc("cnt1_sync", 6'h16, 16'h1234);
		rdc("cnt2_free", 6'h26, 16'h0000);
	endtask
	// Start then stop at once: two ticks take fffe through ffff to 0
	// Reset general registers sit at ffff, so all four match flags rise too
	task automatic t_overflow();
		i_cpu.wr(6'h06, 16'hfffe, 2'h3);
		i_cpu.wr(6'h04, 16'h1000, 2'h2);
		i_cpu.wr(6'h30, 16'h0100, 2'h2);
		i_cpu.wr(6'h30, 16'h0000, 2'h2);
		rdc("cnt0_wrap", 6'h06, 16'h0000);
		rdc("ovf_flag", 6'h04, 16'h101f);
		chk("irq0_ovf", {15'h0000, irq[0]}, 16'h0001);
		i_cpu.wr(6'h04, 16'h0000, 2'h1);
		idle(2);
		chk("irq0_clr", {15'h0000, irq[0]}, 16'h0000);
	endtask
	// Period of four ticks, six ticks run; channel 1 cleared along
	task automatic t_period();
		i_cpu.wr(6'h00, 16'h2000, 2'h2);
		i_cpu.wr(6'h10, 16'h6000, 2'h2);
		i_cpu.wr(6'h08, 16'h0003, 2'h3);
		i_cpu.wr(6'h02, 16'h0003, 2'h1);
		i_cpu.wr(6'h04, 16'h0100, 2'h2);
		i_cpu.wr(6'h06, 16'h0000, 2'h3);
		i_cpu.wr(6'h30, 16'h0300, 2'h2);
		idle(4);
		i_cpu.wr(6'h30, 16'h0000, 2'h2);
		rdc("cnt0_period", 6'h06, 16'h0002);
		rdc("cnt1_syncclr", 6'h16, 16'h0002);
		rdc("match_flag", 6'h04, 16'h0101);
		chk("irq0_match", {15'h0000, irq[0]}, 16'h0001);
		chk("pin0_toggle", {15'h0000, pin_o[0]}, 16'h0001);
		chk("pin0_oe", {15'h0000, pin_oe[0]}, 16'h0001);
	endtask
	// High commanded on a pin already high: no dip
	task automatic t_steady();
		i_cpu.wr(6'h02, 16'h0006, 2'h1);
		i_cpu.wr(6'h06, 16'h0000, 2'h3);
		i_cpu.wr(6'h30, 16'h0100, 2'h2);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_i);
			#1;
			chk("pin0_steady", {15'h0000, pin_o[0]}, 16'h0001);
		end
		i_cpu.wr(6'h30, 16'h0000, 2'h2);
	endtask
	// Stopped counter, rising-edge capture on B with buffer D
	task automatic t_capture();
		i_cpu.wr(6'h00, 16'h0020, 2'h3);
		i_cpu.wr(6'h02, 16'h0080, 2'h1);
		i_cpu.wr(6'h06, 16'h0100, 2'h3);
		@(posedge clk_i) pin_drv[1] <= 1'b1;
		idle(3);
		rdc("grb_cap", 6'h0a, 16'h0100);
		rdc("grd_old", 6'h0e, 16'hffff);
		i_cpu.wr(6'h06, 16'h0200, 2'h3);
		@(posedge clk_i) pin_drv[1] <= 1'b0;
		idle(3);
		rdc("grb_fall", 6'h0a, 16'h0100);
		@(posedge clk_i) pin_drv[1] <= 1'b1;
		idle(3);
		rdc("grb_cap2", 6'h0a, 16'h0200);
		rdc("grd_buf", 6'h0e, 16'h0100);
	endtask
	// Buffered period A from C, then a capture on B clears the counter
	task automatic t_buffer();
		i_cpu.wr(6'h00, 16'h2010, 2'h3);
		i_cpu.wr(6'h08, 16'h0003, 2'h3);
		i_cpu.wr(6'h0c, 16'h0005, 2'h3);
		i_cpu.wr(6'h06, 16'h0000, 2'h3);
		i_cpu.wr(6'h30, 16'h0100, 2'h2);
		idle(4);
		i_cpu.wr(6'h30, 16'h0000, 2'h2);
		rdc("gra_from_buf", 6'h08, 16'h0005);
		rdc("cnt0_buffered", 6'h06, 16'h0002);
		i_cpu.wr(6'h00, 16'h4000, 2'h3);
		i_cpu.wr(6'h06, 16'h0077, 2'h3);
		@(posedge clk_i) pin_drv[1] <= 1'b0;
		@(posedge clk_i) pin_drv[1] <= 1'b1;
		idle(3);
		rdc("cnt0_capclr", 6'h06, 16'h0000);
		rdc("grb_capclr", 6'h0a, 16'h0077);
	endtask
	// Quadrature on channel 1: four steps up, then two down
	task automatic t_phase();
		i_cpu.wr(6'h10, 16'h0004, 2'h3);
		i_cpu.wr(6'h16, 16'h0010, 2'h3);
		i_cpu.wr(6'h30, 16'h0200, 2'h2);
		@(posedge clk_i) ext_drv[1:0] <= 2'h1;
		@(posedge clk_i) ext_drv[1:0] <= 2'h3;
		@(posedge clk_i) ext_drv[1:0] <= 2'h2;
		@(posedge clk_i) ext_drv[1:0] <= 2'h0;
		@(posedge clk_i) ext_drv[1:0] <= 2'h2;
		@(posedge clk_i) ext_drv[1:0] <= 2'h3;
		i_cpu.wr(6'h30, 16'h0000, 2'h2);
		rdc("cnt1_phase", 6'h16, 16'h0012);
	endtask
	// Pwm1 on A: match A drives high, match B drives low and clears
	task automatic t_pwm();
		i_cpu.wr(6'h00, 16'h4002, 2'h3);
		i_cpu.wr(6'h08, 16'h0001, 2'h3);
		i_cpu.wr(6'h0a, 16'h0003, 2'h3);
		i_cpu.wr(6'h02, 16'h0012, 2'h1);
		i_cpu.wr(6'h06, 16'h0000, 2'h3);
		i_cpu.wr(6'h30, 16'h0100, 2'h2);
		idle(4);
		i_cpu.wr(6'h30, 16'h0000, 2'h2);
		rdc("cnt0_pwm1", 6'h06, 16'h0002);
		chk("pin0_pwm1", {15'h0000, pin_o[0]}, 16'h0001);
		chk("pin1_oe_pwm1", {15'h0000, pin_oe[1]}, 16'h0000);
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_access();
		t_preset();
		t_overflow();
		t_period();
		t_steady();
		t_capture();
		t_buffer();
		t_phase();
		t_pwm();
		test_done();
	end
	// Watchdog, well beyond the few hundred cycles the run needs
	initial begin
		repeat (3000) @(posedge clk_i);
		failures++;
		test_done();
	end
endmodule

// [tb/mpt_cpu_model.sv]
`timescale 1ns/1ps
module mpt_cpu_model (
	// Clock
	input wire logic clk_i,
	// Register bus
	output logic bus_cs_o,
	output logic bus_we_o,
	output logic [1:0] bus_be_o,
	output logic [mpt_pkg::ADDR_W-1:0] bus_addr_o,
	output mpt_pkg::mpt_word_t bus_wdata_o,
	input wire mpt_pkg::mpt_word_t bus_rdata_i
);
	import mpt_pkg::*;
	// Idle bus at time zero
	initial begin
		bus_cs_o = 1'b0;
		bus_we_o = 1'b0;
		bus_be_o = 2'h0;
		bus_addr_o = '0;
		bus_wdata_o = '0;
	end
	// One cycle request; released lines flip so stale values never look valid
	task automatic access(input logic we, input logic [5:0] a, input mpt_word_t d,
		input logic [1:0] be);
		@(posedge clk_i);
		bus_cs_o <= 1'b1;
		bus_we_o <= we;
		bus_addr_o <= a;
		bus_wdata_o <= d;
		bus_be_o <= be;
		@(posedge clk_i);
		bus_cs_o <= 1'b0;
		bus_we_o <= 1'b0;
		bus_addr_o <= ~a;
		bus_wdata_o <= ~d;
		bus_be_o <= ~be;
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input mpt_word_t d, input logic [1:0] be);
		access(1'b1, a, d, be);
	endtask
	// Reads always use both lanes
	task automatic rd(input logic [5:0] a, output mpt_word_t d);
		access(1'b0, a, 16'h0000, 2'h3);
		d = bus_rdata_i;
	endtask
endmodule
